// >>> sacw_defines.svh
// register addresses, field positions, reset values and timing counts of the converter control
`ifndef SACW_DEFINES_SVH
`define SACW_DEFINES_SVH

// ****************************************
// register addresses on the special function register bus
// ****************************************
`define SACW_ADDR_CONFIG 8'hBC
`define SACW_ADDR_RES_LO 8'hBE
`define SACW_ADDR_RES_HI 8'hBF
`define SACW_ADDR_GT_LO 8'hC4
`define SACW_ADDR_GT_HI 8'hC5
`define SACW_ADDR_LT_LO 8'hC6
`define SACW_ADDR_LT_HI 8'hC7
`define SACW_ADDR_CONTROL 8'hE8

// ****************************************
// field positions
// ****************************************
`define SACW_CFG_DIV_HI 7
`define SACW_CFG_DIV_LO 3
`define SACW_CFG_GAIN_HI 2
`define SACW_CFG_GAIN_LO 0
`define SACW_CTL_EN 7
`define SACW_CTL_TM 6
`define SACW_CTL_DONE 5
`define SACW_CTL_BUSY 4
`define SACW_CTL_SRC_HI 3
`define SACW_CTL_SRC_LO 2
`define SACW_CTL_WIN 1
`define SACW_CTL_LJ 0

// ****************************************
// reset values
// ****************************************
`define SACW_RST_CONFIG 8'hF8
`define SACW_RST_CONTROL 8'h00
`define SACW_RST_RESULT 16'h0000
`define SACW_RST_GT 16'hFFFF
`define SACW_RST_LT 16'h0000

// ****************************************
// start sources
// ****************************************
`define SACW_SRC_SOFTWARE 2'h0
`define SACW_SRC_TIMER3 2'h1
`define SACW_SRC_EXTERNAL 2'h2
`define SACW_SRC_TIMER2 2'h3

// ****************************************
// timing
// ****************************************
`define SACW_SYS_CLK_KHZ 10000
`define SACW_SAR_MAX_KHZ 2500
`define SACW_SAR_MIN_DIV ((`SACW_SYS_CLK_KHZ + `SACW_SAR_MAX_KHZ - 1) / `SACW_SAR_MAX_KHZ - 1)
`define SACW_TRACK_SAR_CLKS 5'h03
`define SACW_CONV_SAR_CLKS 5'h10

`endif

// >>> sacw_pkg.sv
// types shared by the converter control logic
`default_nettype none
`include "sacw_defines.svh"

package sacw_pkg;

   // ****************************************
   // sequencer states
   // ****************************************
   typedef enum logic [1:0] {
      SACW_IDLE = 2'b00,
      SACW_TRACK = 2'b01,
      SACW_CONVERT = 2'b10
   } sacw_state_t;

   // ****************************************
   // amplifier gain codes driven to the analog side
   // ****************************************
   typedef enum logic [2:0] {
      SACW_GAIN_X1 = 3'b000,
      SACW_GAIN_X2 = 3'b001,
      SACW_GAIN_X4 = 3'b010,
      SACW_GAIN_X8 = 3'b011,
      SACW_GAIN_X16 = 3'b100,
      SACW_GAIN_HALF = 3'b101
   } sacw_gain_t;

   // ****************************************
   // complete state of the block
   // ****************************************
   typedef struct packed {
      sacw_state_t state;
      logic [7:0] config_reg;
      logic enable;
      logic track_mode;
      logic done_flag;
      logic busy;
      logic [1:0] start_src;
      logic win_flag;
      logic left_justify;
      logic [15:0] result;
      logic [15:0] gt_limit;
      logic [15:0] lt_limit;
      logic [4:0] sar_cnt;
      logic [4:0] phase_cnt;
      logic ext_prev;
      logic [7:0] rdata;
      logic sar_tick;
      logic track;
      logic convert;
      logic active;
      sacw_gain_t gain;
   } sacw_state_vec_t;

endpackage : sacw_pkg

`default_nettype wire

// >>> sacw_ctrl.sv
// converter control: sar clock, start sources, busy/done flags, justification and window detector
//
// Overview of operation
// - sar clock equals system clock divided by divider field plus one; divider values below 3 act as 3.
// - three-bit gain field selects amplifier gain one to sixteen or one half.
// - enable bit low keeps converter shut down; high allows conversions.
// - track mode zero and enabled: track continuously while not converting.
// - done flag sets as busy falls; only software clears it.
// - busy reads one from start through tracking and conversion, zero otherwise.
// - writing one to busy starts conversion only with software source; zero ignored.
// - start source picks software write, timer 3, external rising edge, timer 2.
// - track mode one, non-external sources: three sar clocks tracking, then conversion.
// - track mode one, external source: track while pin low, convert on rise.
// - window flag sets on window match and stays until software clears it.
// - justify bit zero gives right-justified, one gives left-justified result.
// - right-justified: sign-extend differential, zero-fill single-ended upper high-byte bits.
// - left-justified: ten bits in high byte and low-byte bits 7:6.
// - single-ended results unsigned; differential results two's complement.
// - every result is compared against two programmed limits.
// - limits are sixteen-bit words, each split into high and low byte registers.
// - limit ordering selects inside-window or outside-window detection.
// - less-than above greater-than: flag when result strictly between limits.
// - less-than below greater-than: flag when result above greater or below less.
// - conversion spans sixteen sar clocks; sar clock kept at most 2.5 MHz.
`default_nettype none
`include "sacw_defines.svh"

module sacw_ctrl (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   input wire logic timer2_ovf_i,
   input wire logic timer3_ovf_i,
   input wire logic ext_convert_start_i,
   input wire logic [9:0] sample_code_i,
   input wire logic differential_i,
   output logic converter_active_o,
   output logic track_o,
   output logic convert_o,
   output logic sar_tick_o,
   output logic conversion_busy_o,
   output logic [2:0] amp_gain_select_o
);

   // ****************************************
   // state
   // ****************************************
   sacw_pkg::sacw_state_vec_t st_ff;
   sacw_pkg::sacw_state_vec_t nxt_st;

   logic [4:0] sar_clock_divider;
   logic [4:0] div_eff;
   logic tick_now;
   logic ext_rise;
   logic sel_trigger;
   logic sw_busy_write;
   logic start_seq;
   logic finish;
   logic [15:0] new_result;
   logic [15:0] key_res;
   logic [15:0] key_gt;
   logic [15:0] key_lt;
   logic match;
   logic wr_ctl;

   // ****************************************
   // helpers
   // ****************************************
   // differential words compare as signed: flipping the sign bit makes an unsigned compare order them
   function automatic logic [15:0] sacw_key(input logic [15:0] w, input logic diff);
      logic [15:0] k;
      k = w;
      if (diff) begin
         k[15] = ~w[15];
      end
      return k;
   endfunction

   always_comb begin
      // ****************************************
      // defaults
      // ****************************************
      nxt_st = st_ff;
      wr_ctl = sfr_wr_i && (sfr_addr_i == `SACW_ADDR_CONTROL);

      // ****************************************
      // sar clock divider
      // ****************************************
      sar_clock_divider = st_ff.config_reg[`SACW_CFG_DIV_HI:`SACW_CFG_DIV_LO];
      // a too-small divider would overclock the converter, so it is held at the safe minimum
      if (sar_clock_divider < 5'(`SACW_SAR_MIN_DIV)) begin
         div_eff = 5'(`SACW_SAR_MIN_DIV);
      end else begin
         div_eff = sar_clock_divider;
      end
      tick_now = (st_ff.sar_cnt >= div_eff);

      // ****************************************
      // start trigger selection
      // ****************************************
      ext_rise = ext_convert_start_i && !st_ff.ext_prev;
      sw_busy_write = wr_ctl && sfr_wdata_i[`SACW_CTL_BUSY];
      case (st_ff.start_src)
         `SACW_SRC_SOFTWARE: begin
            sel_trigger = sw_busy_write;
         end
         `SACW_SRC_TIMER3: begin
            sel_trigger = timer3_ovf_i;
         end
         `SACW_SRC_EXTERNAL: begin
            sel_trigger = ext_rise;
         end
         `SACW_SRC_TIMER2: begin
            sel_trigger = timer2_ovf_i;
         end
         default: begin
            sel_trigger = 1'b0;
         end
      endcase
      // triggers during a sequence or while shut down are simply dropped
      start_seq = sel_trigger && st_ff.enable && (st_ff.state == sacw_pkg::SACW_IDLE);

      // ****************************************
      // result word formatting
      // ****************************************
      if (st_ff.left_justify) begin
         new_result = {sample_code_i, 6'h00};
      end else if (differential_i) begin
         new_result = {{6{sample_code_i[9]}}, sample_code_i};
      end else begin
         new_result = {6'h00, sample_code_i};
      end

      // ****************************************
      // window compare on the word as it will be stored
      // ****************************************
      key_res = sacw_key(new_result, differential_i);
      key_gt = sacw_key(st_ff.gt_limit, differential_i);
      key_lt = sacw_key(st_ff.lt_limit, differential_i);
      if (key_lt > key_gt) begin
         match = (key_res < key_lt) && (key_res > key_gt);
      end else begin
         match = (key_res > key_gt) || (key_res < key_lt);
      end

      // ****************************************
      // register writes
      // ****************************************
      finish = 1'b0;
      nxt_st.ext_prev = ext_convert_start_i;
      if (sfr_wr_i) begin
         case (sfr_addr_i)
            `SACW_ADDR_CONFIG: begin
               nxt_st.config_reg = sfr_wdata_i;
            end
            `SACW_ADDR_CONTROL: begin
               nxt_st.enable = sfr_wdata_i[`SACW_CTL_EN];
               nxt_st.track_mode = sfr_wdata_i[`SACW_CTL_TM];
               nxt_st.done_flag = sfr_wdata_i[`SACW_CTL_DONE];
               nxt_st.start_src = sfr_wdata_i[`SACW_CTL_SRC_HI:`SACW_CTL_SRC_LO];
               nxt_st.win_flag = sfr_wdata_i[`SACW_CTL_WIN];
               nxt_st.left_justify = sfr_wdata_i[`SACW_CTL_LJ];
            end
            `SACW_ADDR_RES_HI: begin
               nxt_st.result[15:8] = sfr_wdata_i;
            end
            `SACW_ADDR_RES_LO: begin
               nxt_st.result[7:0] = sfr_wdata_i;
            end
            `SACW_ADDR_GT_HI: begin
               nxt_st.gt_limit[15:8] = sfr_wdata_i;
            end
            `SACW_ADDR_GT_LO: begin
               nxt_st.gt_limit[7:0] = sfr_wdata_i;
            end
            `SACW_ADDR_LT_HI: begin
               nxt_st.lt_limit[15:8] = sfr_wdata_i;
            end
            `SACW_ADDR_LT_LO: begin
               nxt_st.lt_limit[7:0] = sfr_wdata_i;
            end
            default: begin
            end
         endcase
      end

      // ****************************************
      // sar clock counter, restarted at each start so periods line up
      // ****************************************
      if (start_seq || tick_now) begin
         nxt_st.sar_cnt = 5'h00;
      end else begin
         nxt_st.sar_cnt = st_ff.sar_cnt + 5'h01;
      end

      // ****************************************
      // sequencer
      // ****************************************
      case (st_ff.state)
         sacw_pkg::SACW_IDLE: begin
            if (start_seq) begin
               nxt_st.busy = 1'b1;
               nxt_st.phase_cnt = 5'h00;
               if (st_ff.track_mode && (st_ff.start_src != `SACW_SRC_EXTERNAL)) begin
                  nxt_st.state = sacw_pkg::SACW_TRACK;
               end else begin
                  nxt_st.state = sacw_pkg::SACW_CONVERT;
               end
            end
         end
         sacw_pkg::SACW_TRACK: begin
            if (tick_now) begin
               if (st_ff.phase_cnt + 5'h01 >= `SACW_TRACK_SAR_CLKS) begin
                  nxt_st.phase_cnt = 5'h00;
                  nxt_st.state = sacw_pkg::SACW_CONVERT;
               end else begin
                  nxt_st.phase_cnt = st_ff.phase_cnt + 5'h01;
               end
            end
         end
         sacw_pkg::SACW_CONVERT: begin
            if (tick_now) begin
               if (st_ff.phase_cnt + 5'h01 >= `SACW_CONV_SAR_CLKS) begin
                  finish = 1'b1;
                  nxt_st.phase_cnt = 5'h00;
                  nxt_st.state = sacw_pkg::SACW_IDLE;
               end else begin
                  nxt_st.phase_cnt = st_ff.phase_cnt + 5'h01;
               end
            end
         end
         default: begin
            nxt_st.state = sacw_pkg::SACW_IDLE;
            nxt_st.phase_cnt = 5'h00;
         end
      endcase

      // ****************************************
      // completion: result, busy fall, flags; hardware set wins over a software clear
      // ****************************************
      if (finish) begin
         nxt_st.result = new_result;
         nxt_st.busy = 1'b0;
         nxt_st.done_flag = 1'b1;
         nxt_st.win_flag = nxt_st.win_flag || match;
      end

      // ****************************************
      // shutdown aborts any sequence without a result
      // ****************************************
      if (!nxt_st.enable) begin
         nxt_st.state = sacw_pkg::SACW_IDLE;
         nxt_st.busy = 1'b0;
         nxt_st.phase_cnt = 5'h00;
      end

      // ****************************************
      // analog side controls
      // ****************************************
      nxt_st.active = nxt_st.enable;
      nxt_st.sar_tick = tick_now && nxt_st.enable;
      nxt_st.convert = nxt_st.enable && (nxt_st.state == sacw_pkg::SACW_CONVERT);
      if (!nxt_st.enable || (nxt_st.state == sacw_pkg::SACW_CONVERT)) begin
         nxt_st.track = 1'b0;
      end else if (nxt_st.state == sacw_pkg::SACW_TRACK) begin
         nxt_st.track = 1'b1;
      end else if (!nxt_st.track_mode) begin
         nxt_st.track = 1'b1;
      end else if (nxt_st.start_src == `SACW_SRC_EXTERNAL) begin
         // the external party keeps the pin low long enough to settle the input
         nxt_st.track = !ext_convert_start_i;
      end else begin
         nxt_st.track = 1'b0;
      end

      casez (nxt_st.config_reg[`SACW_CFG_GAIN_HI:`SACW_CFG_GAIN_LO])
         3'b000: begin
            nxt_st.gain = sacw_pkg::SACW_GAIN_X1;
         end
         3'b001: begin
            nxt_st.gain = sacw_pkg::SACW_GAIN_X2;
         end
         3'b010: begin
            nxt_st.gain = sacw_pkg::SACW_GAIN_X4;
         end
         3'b011: begin
            nxt_st.gain = sacw_pkg::SACW_GAIN_X8;
         end
         3'b10?: begin
            nxt_st.gain = sacw_pkg::SACW_GAIN_X16;
         end
         default: begin
            nxt_st.gain = sacw_pkg::SACW_GAIN_HALF;
         end
      endcase

      // ****************************************
      // read data, one cycle after the address; unmapped reads zero
      // ****************************************
      case (sfr_addr_i)
         `SACW_ADDR_CONFIG: begin
            nxt_st.rdata = st_ff.config_reg;
         end
         `SACW_ADDR_CONTROL: begin
            nxt_st.rdata = {st_ff.enable, st_ff.track_mode, st_ff.done_flag, st_ff.busy,
                            st_ff.start_src, st_ff.win_flag, st_ff.left_justify};
         end
         `SACW_ADDR_RES_HI: begin
            nxt_st.rdata = st_ff.result[15:8];
         end
         `SACW_ADDR_RES_LO: begin
            nxt_st.rdata = st_ff.result[7:0];
         end
         `SACW_ADDR_GT_HI: begin
            nxt_st.rdata = st_ff.gt_limit[15:8];
         end
         `SACW_ADDR_GT_LO: begin
            nxt_st.rdata = st_ff.gt_limit[7:0];
         end
         `SACW_ADDR_LT_HI: begin
            nxt_st.rdata = st_ff.lt_limit[15:8];
         end
         `SACW_ADDR_LT_LO: begin
            nxt_st.rdata = st_ff.lt_limit[7:0];
         end
         default: begin
            nxt_st.rdata = 8'h00;
         end
      endcase
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st_ff <= '0;
         {st_ff.enable, st_ff.track_mode, st_ff.done_flag, st_ff.busy, st_ff.start_src, st_ff.win_flag,
            st_ff.left_justify} <= `SACW_RST_CONTROL;
         st_ff.config_reg <= `SACW_RST_CONFIG;
         st_ff.result <= `SACW_RST_RESULT;
         st_ff.gt_limit <= `SACW_RST_GT;
         st_ff.lt_limit <= `SACW_RST_LT;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************
   // outputs, all straight from flip-flops
   // ****************************************
   assign sfr_rdata_o = st_ff.rdata;
   assign converter_active_o = st_ff.active;
   assign track_o = st_ff.track;
   assign convert_o = st_ff.convert;
   assign sar_tick_o = st_ff.sar_tick;
   assign conversion_busy_o = st_ff.busy;
   assign amp_gain_select_o = st_ff.gain;

endmodule // sacw_ctrl

`default_nettype wire

// >>> sacw_cpu_model.sv
// cpu core model driving the special function register bus
`default_nettype none
`include "sacw_defines.svh"

module sacw_cpu_model (
   input wire logic clk_i,
   input wire logic [7:0] sfr_rdata_i,
   output var logic [7:0] sfr_addr_o,
   output var logic sfr_wr_o,
   output var logic [7:0] sfr_wdata_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // bus cycles
   // ****************************************
   initial begin
      sfr_addr_o = 8'h00;
      sfr_wr_o = 1'b0;
      sfr_wdata_o = 8'h00;
   end

   // one-cycle strobe; address and data held until the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i) #1;
      sfr_addr_o = a;
      sfr_wr_o = 1'b1;
      sfr_wdata_o = d;
      @(posedge clk_i) #1;
      sfr_wr_o = 1'b0;
      sfr_wdata_o = ~d;
   endtask

   // read data is registered, so it shows one edge after the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i) #1;
      sfr_addr_o = a;
      @(posedge clk_i) #1;
      d = sfr_rdata_i;
   endtask
endmodule // sacw_cpu_model

`default_nettype wire

// >>> sacw_ctrl_sva.sv
// concurrent checks on the converter control ports
`default_nettype none
`include "sacw_defines.svh"

module sacw_ctrl_sva (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic timer2_ovf_i,
   input wire logic timer3_ovf_i,
   input wire logic ext_convert_start_i,
   input wire logic [9:0] sample_code_i,
   input wire logic differential_i,
   input wire logic converter_active_o,
   input wire logic track_o,
   input wire logic convert_o,
   input wire logic sar_tick_o,
   input wire logic conversion_busy_o,
   input wire logic [2:0] amp_gain_select_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   // ****************************************
   // sar ticks seen while converting
   // ****************************************
   logic [5:0] ticks_ff;
   logic [5:0] nxt_ticks;
   always_comb begin
      nxt_ticks = ticks_ff;
      if (!convert_o) nxt_ticks = 6'h00;
      else if (sar_tick_o) nxt_ticks = ticks_ff + 6'h01;
   end
   always_ff @(posedge clk_i) begin
      ticks_ff <= resetn_i ? nxt_ticks : 6'h00;
   end
   // a busy write only counts against the start source already stored
   logic [1:0] src_ff;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) src_ff <= 2'h0;
      else if (sfr_wr_i && sfr_addr_i == `SACW_ADDR_CONTROL) src_ff <= sfr_wdata_i[3:2];
   end

   // ****************************************
   // assertions
   // ****************************************
   sequence sw_go;
      sfr_wr_i && sfr_addr_i == `SACW_ADDR_CONTROL && sfr_wdata_i[7] && sfr_wdata_i[4] && src_ff == 2'h0;
   endsequence
   sequence seq_idle_on;
      converter_active_o && !conversion_busy_o;
   endsequence
   // a tick lands on the edge where the divider wraps, so one tick of slack
   chk_conv_len: assert property ($fell(convert_o) && converter_active_o |-> ticks_ff inside {[15:17]})
      else $error("conversion length out of range");
   chk_tick_gap: assert property (sar_tick_o |=> !sar_tick_o [*3])
      else $error("sar ticks closer than four cycles");
   chk_tick_enabled: assert property (sar_tick_o |-> converter_active_o)
      else $error("sar tick while shut down");
   chk_off_idle: assert property (!converter_active_o |-> !conversion_busy_o && !convert_o && !track_o)
      else $error("activity while shut down");
   chk_convert_busy: assert property (convert_o |-> conversion_busy_o && !track_o)
      else $error("converting without busy");
   chk_gain_code: assert property (amp_gain_select_o <= 3'h5)
      else $error("gain code out of range");
   chk_sw_start: assert property (sw_go ##0 seq_idle_on |=> conversion_busy_o)
      else $error("software start not taken");
   chk_zero_write: assert property (sfr_wr_i && sfr_addr_i == `SACW_ADDR_CONTROL && !sfr_wdata_i[4]
      && !conversion_busy_o && !timer2_ovf_i && !timer3_ovf_i && !ext_convert_start_i |=> !conversion_busy_o)
      else $error("busy rose on a zero write");
   chk_busy_fall: assert property ($fell(conversion_busy_o) && converter_active_o |-> $past(convert_o))
      else $error("busy fell outside conversion");
   chk_no_restart: assert property (convert_o |=> !(track_o && conversion_busy_o))
      else $error("conversion restarted");
   chk_unmapped_zero: assert property (!($past(sfr_addr_i) inside {8'hBC, 8'hBE, 8'hBF, 8'hC4, 8'hC5, 8'hC6, 8'hC7,
      8'hE8}) |-> sfr_rdata_o == 8'h00)
      else $error("unmapped read not zero");
endmodule // sacw_ctrl_sva

bind sacw_ctrl sacw_ctrl_sva chk (.clk_i, .resetn_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o,
   .timer2_ovf_i, .timer3_ovf_i, .ext_convert_start_i, .sample_code_i, .differential_i, .converter_active_o,
   .track_o, .convert_o, .sar_tick_o, .conversion_busy_o, .amp_gain_select_o);

`default_nettype wire

// >>> test_sar_adc_control_window.sv
// self-checking bench of the converter control
`default_nettype none
`include "sacw_defines.svh"

module test_sar_adc_control_window;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
   logic sfr_wr_i;
   logic timer2_ovf_i = 1'b0;
   logic timer3_ovf_i = 1'b0;
   logic ext_convert_start_i = 1'b0;
   logic [9:0] sample_code_i = 10'h000;
   logic differential_i = 1'b0;
   logic converter_active_o, track_o, convert_o, sar_tick_o, conversion_busy_o;
   logic [2:0] amp_gain_select_o;
   int mismatches = 0;
   int n_checks = 0;

   always #50 clk_i = ~clk_i;

   sacw_cpu_model cpu (.clk_i(clk_i), .sfr_rdata_i(sfr_rdata_o), .sfr_addr_o(sfr_addr_i), .sfr_wr_o(sfr_wr_i),
      .sfr_wdata_o(sfr_wdata_i));
   sacw_ctrl DUT (.clk_i, .resetn_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o, .timer2_ovf_i,
      .timer3_ovf_i, .ext_convert_start_i, .sample_code_i, .differential_i, .converter_active_o, .track_o,
      .convert_o, .sar_tick_o, .conversion_busy_o, .amp_gain_select_o);

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // trig 0 means the busy write itself is the trigger
   task automatic conv(input logic [7:0] cfg, input logic [7:0] ctl, input logic [1:0] trig,
      input logic [9:0] code, input logic d, input int cyc, input logic [15:0] res, output logic [7:0] c);
      int n;
      logic [7:0] hi, lo;
      cpu.wr(`SACW_ADDR_CONFIG, cfg);
      sample_code_i = code;
      differential_i = d;
      cpu.wr(`SACW_ADDR_CONTROL, ctl);
      if (trig != 2'h0) begin
         @(posedge clk_i) #1;
         timer3_ovf_i = (trig == `SACW_SRC_TIMER3);
         timer2_ovf_i = (trig == `SACW_SRC_TIMER2);
         ext_convert_start_i = (trig == `SACW_SRC_EXTERNAL);
         @(posedge clk_i) #1;
         timer3_ovf_i = 1'b0;
         timer2_ovf_i = 1'b0;
      end
      n = 0;
      while (conversion_busy_o === 1'b1 && n < 2000) begin
         @(posedge clk_i) #1;
         n++;
      end
      ext_convert_start_i = 1'b0;
      check(16'(n), 16'(cyc));
      cpu.rd(`SACW_ADDR_RES_HI, hi);
      cpu.rd(`SACW_ADDR_RES_LO, lo);
      check({hi, lo}, res);
      cpu.rd(`SACW_ADDR_CONTROL, c);
      check(16'(c[5:4]), 16'h0002);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic test_regs();
      logic [7:0] a [9] = '{8'hBC, 8'hBE, 8'hBF, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hE8, 8'hA0};
      logic [7:0] e [9] = '{8'hF8, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [7:0] v;
      cpu.wr(8'hA0, 8'h5A);
      for (int i = 0; i < 9; i++) begin
         cpu.rd(a[i], v);
         check(16'(v), 16'(e[i]));
      end
      $display("test regs done");
   endtask

   task automatic test_gain();
      logic [2:0] e [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};
      for (int i = 0; i < 8; i++) begin
         cpu.wr(`SACW_ADDR_CONFIG, {5'h1F, 3'(i)});
         @(posedge clk_i) #1;
         check(16'(amp_gain_select_o), 16'(e[i]));
      end
      $display("test gain done");
   endtask

   task automatic test_tick();
      int n;
      cpu.wr(`SACW_ADDR_CONFIG, 8'h38);
      cpu.wr(`SACW_ADDR_CONTROL, 8'h80);
      for (n = 0; n < 40 && sar_tick_o !== 1'b1; n++) @(posedge clk_i) #1;
      for (n = 1; n < 40; n++) begin
         @(posedge clk_i) #1;
         if (sar_tick_o === 1'b1) break;
      end
      check(16'(n), 16'h0008);
      check(16'(track_o), 16'h0001);
      $display("test tick done");
   endtask

   // a second busy write mid-run must not stretch or restart the conversion
   task automatic test_ignore();
      int n;
      cpu.wr(`SACW_ADDR_CONTROL, 8'h00);
      cpu.wr(`SACW_ADDR_CONTROL, 8'h10);
      @(posedge clk_i) #1;
      check(16'(conversion_busy_o), 16'h0000);
      cpu.wr(`SACW_ADDR_CONFIG, 8'h18);
      cpu.wr(`SACW_ADDR_CONTROL, 8'h80);
      cpu.wr(`SACW_ADDR_CONTROL, 8'h90);
      repeat (10) @(posedge clk_i);
      #1;
      cpu.wr(`SACW_ADDR_CONTROL, 8'h90);
      n = 12;
      while (conversion_busy_o === 1'b1 && n < 2000) begin
         @(posedge clk_i) #1;
         n++;
      end
      check(16'(n), 16'd64);
      cpu.wr(`SACW_ADDR_CONTROL, 8'h80);
      @(posedge clk_i) #1;
      check(16'(conversion_busy_o), 16'h0000);
      $display("test ignore done");
   endtask

   task automatic test_modes();
      logic [7:0] c;
      conv(8'h18, 8'h90, 2'h0, 10'h2A5, 1'b0, 64, 16'h02A5, c);
      conv(8'h18, 8'h90, 2'h0, 10'h200, 1'b1, 64, 16'hFE00, c);
      conv(8'h00, 8'hC4, 2'h1, 10'h3FF, 1'b1, 76, 16'hFFFF, c);
      conv(8'h18, 8'h8D, 2'h3, 10'h3FF, 1'b1, 64, 16'hFFC0, c);
      conv(8'h18, 8'h88, 2'h2, 10'h201, 1'b0, 64, 16'h0201, c);
      conv(8'h18, 8'hC9, 2'h2, 10'h201, 1'b0, 64, 16'h8040, c);
      cpu.wr(`SACW_ADDR_CONTROL, 8'h80);
      cpu.rd(`SACW_ADDR_CONTROL, c);
      check(16'(c), 16'h0080);
      $display("test modes done");
   endtask

   task automatic test_window();
      logic [15:0] g [4] = '{16'h0100, 16'h0100, 16'h0200, 16'h0200};
      logic [15:0] l [4] = '{16'h0200, 16'h0200, 16'h0100, 16'h0100};
      logic [9:0] s [4] = '{10'h180, 10'h100, 10'h080, 10'h180};
      logic w [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      logic [7:0] c;
      for (int i = 0; i < 4; i++) begin
         cpu.wr(`SACW_ADDR_GT_HI, g[i][15:8]);
         cpu.wr(`SACW_ADDR_GT_LO, g[i][7:0]);
         cpu.wr(`SACW_ADDR_LT_HI, l[i][15:8]);
         cpu.wr(`SACW_ADDR_LT_LO, l[i][7:0]);
         conv(8'h18, 8'h90, 2'h0, s[i], 1'b0, 64, {6'h00, s[i]}, c);
         check(16'(c[1]), 16'(w[i]));
      end
      $display("test window done");
   endtask

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      repeat (16) @(posedge clk_i);
      #1;
      resetn_i = 1'b1;
      test_regs();
      test_gain();
      test_tick();
      test_ignore();
      test_modes();
      test_window();
      results();
   end

   // the whole run needs about 1000 cycles
   initial begin
      #(8000 * 100);
      mismatches++;
      results();
   end
endmodule // test_sar_adc_control_window

`default_nettype wire
